//--- src/asac_dev.sv
// Converter end: select sequencing, abort, address capture, serial result and conversion model.
// Assumes link pins are asynchronous to sys_clk; the user side supplies the selected analog level.
//
// How it works
// - Every transfer starts at select falling.
// - Select falling mid-cycle aborts, result kept.
// - Host avoids select falling near conversion end.
// - Codes saturate at both reference limits.
// - Ignore inputs for filter plus two ticks.
// - Host waits 1.425 us before address.
// - Host rises eleventh edge within 9.5 us.
// - Host shift clock at most 2.1 MHz.
// - Address MSB first on first four rises.
// - Late eleventh rise loses sync until reselect.
// - Select rising floats data, stops input.
`timescale 1ns/1ps
module asac_dev (
   input  wire logic                               sys_clk,
   input  wire logic                               rst_n,
   asac_link_if.dev                                link,
   input  wire logic [asac_pkg::LEVEL_BITS-1:0]    ain_level,
   input  wire logic [asac_pkg::LEVEL_BITS-1:0]    ref_lo,
   input  wire logic [asac_pkg::LEVEL_BITS-1:0]    ref_hi,
   output logic      [asac_pkg::ADDR_BITS-1:0]     chan_q,
   output logic      [asac_pkg::RES_BITS-1:0]      result_q,
   output logic                                    busy_q,
   output logic                                    sync_lost_q
);

   typedef enum logic [1:0] {
      ASAC_IDLE,
      ASAC_SETTLE,
      ASAC_SHIFT,
      ASAC_LOST
   } asac_dev_mode_t;

   typedef struct packed {
      logic [2:0]                          cs_sy;
      logic [2:0]                          clk_sy;
      logic [1:0]                          addr_sy;
      asac_dev_mode_t                      mode;
      logic [asac_pkg::TMR_W-1:0]          tmr;
      logic                                tick_seen;
      logic [asac_pkg::INT_DIV_W-1:0]      div;
      logic [asac_pkg::CNT_W-1:0]          rise_cnt;
      logic [asac_pkg::CNT_W-1:0]          fall_cnt;
      logic [asac_pkg::ADDR_BITS-1:0]      addr_sh;
      logic [asac_pkg::ADDR_BITS-1:0]      chan;
      logic [asac_pkg::RES_BITS-1:0]       out_sh;
      logic                                dout;
      logic                                dout_oe_n;
      logic                                conv;
      logic [asac_pkg::TMR_W-1:0]          conv_tmr;
      logic [asac_pkg::ADDR_BITS-1:0]      conv_chan;
      logic [asac_pkg::RES_BITS-1:0]       result;
      logic                                eoc;
      logic                                lost;
   } asac_dev_st_t;

   asac_dev_st_t                        q;
   asac_dev_st_t                        d;
   logic                                cs_fall;
   logic                                cs_rise;
   logic                                sclk_rise;
   logic                                sclk_fall;
   logic                                int_fall;
   logic [asac_pkg::LEVEL_BITS-1:0]     diff;
   logic [asac_pkg::RES_BITS-1:0]       code;
   logic [asac_pkg::ADDR_BITS-1:0]      addr_next;

   // Edge detectors look only at the second and third synchroniser stages.
   assign cs_fall   = q.cs_sy[2] & ~q.cs_sy[1];
   assign cs_rise   = ~q.cs_sy[2] & q.cs_sy[1];
   assign sclk_rise = ~q.clk_sy[2] & q.clk_sy[1];
   assign sclk_fall = q.clk_sy[2] & ~q.clk_sy[1];

   // The internal system clock falls once per divider wrap.
   assign int_fall  = &q.div;

   assign addr_next = {q.addr_sh[asac_pkg::ADDR_BITS-2:0], q.addr_sy[1]};

   // Result code of the channel being converted.
   always_comb begin
      diff = ain_level - ref_lo;
      if (q.conv_chan == asac_pkg::ADDR_TEST_MID) begin
         code = asac_pkg::RES_MID;
      end else if (q.conv_chan == asac_pkg::ADDR_TEST_LO) begin
         code = asac_pkg::RES_ZERO;
      end else if (q.conv_chan == asac_pkg::ADDR_TEST_HI) begin
         code = asac_pkg::RES_FULL;
      end else if (ain_level <= ref_lo) begin
         code = asac_pkg::RES_ZERO;
      end else if (ain_level >= ref_hi) begin
         code = asac_pkg::RES_FULL;
      end else if (diff > asac_pkg::LEVEL_BITS'(asac_pkg::RES_FULL)) begin
         code = asac_pkg::RES_FULL;
      end else begin
         code = diff[asac_pkg::RES_BITS-1:0];
      end
   end

   always_comb begin
      d         = q;
      d.cs_sy   = {q.cs_sy[1:0], link.cs_n};
      d.clk_sy  = {q.clk_sy[1:0], link.io_clk};
      d.addr_sy = {q.addr_sy[0], link.addr};
      d.div     = q.div + 1'b1;

      // Conversion runs on, even after select rises, until its timer ends.
      if (q.conv) begin
         if (q.conv_tmr != '0) begin
            d.conv_tmr = q.conv_tmr - 1'b1;
         end else begin
            d.conv = 1'b0;
            d.eoc  = 1'b1;
            if (q.mode == ASAC_SHIFT && q.rise_cnt <= asac_pkg::SAMPLE_CNT) begin
               // The eleventh rise has not come yet: the link is out of step.
               d.mode = ASAC_LOST;
               d.lost = 1'b1;
            end else begin
               d.result = code;
            end
         end
      end

      unique case (q.mode)
         ASAC_IDLE: begin
         end
         ASAC_SETTLE: begin
            // Control inputs are not looked at until the filter and two ticks pass.
            if (q.tmr != '0) begin
               d.tmr = q.tmr - 1'b1;
            end else if (int_fall) begin
               d.tick_seen = 1'b1;
               if (q.tick_seen) begin
                  d.mode = ASAC_SHIFT;
               end
            end
         end
         ASAC_SHIFT: begin
            if (sclk_rise) begin
               if (~&q.rise_cnt) begin
                  d.rise_cnt = q.rise_cnt + 1'b1;
               end
               if (q.rise_cnt <= asac_pkg::ADDR_LAST_RISE) begin
                  d.addr_sh = addr_next;
               end
               if (q.rise_cnt == asac_pkg::ADDR_LAST_RISE) begin
                  d.chan = addr_next;
               end
            end
            if (sclk_fall) begin
               if (~&q.fall_cnt) begin
                  d.fall_cnt = q.fall_cnt + 1'b1;
               end
               // Next result bit; zeros follow once all ten have left.
               d.out_sh = {q.out_sh[asac_pkg::RES_BITS-2:0], 1'b0};
               d.dout   = q.out_sh[asac_pkg::RES_BITS-2];
               if (q.fall_cnt == asac_pkg::LAST_SAMPLE) begin
                  d.conv      = 1'b1;
                  d.conv_tmr  = asac_pkg::CONV_TMR;
                  d.conv_chan = q.chan;
                  d.eoc       = 1'b0;
               end
            end
         end
         ASAC_LOST: begin
            // Shift clocks are ignored until select is toggled.
         end
      endcase

      if (cs_rise) begin
         d.mode      = ASAC_IDLE;
         d.dout_oe_n = 1'b1;
      end

      // A new falling select restarts the transfer, keeping result and chan, and wins over any other update.
      if (cs_fall) begin
         d.mode      = ASAC_SETTLE;
         d.tmr       = asac_pkg::FILTER_TMR;
         d.tick_seen = 1'b0;
         d.rise_cnt  = '0;
         d.fall_cnt  = '0;
         d.addr_sh   = '0;
         d.conv      = 1'b0;
         d.eoc       = 1'b1;
         d.lost      = 1'b0;
         d.result    = q.result;
         d.out_sh    = q.result;
         d.dout      = q.result[asac_pkg::RES_BITS-1];
         d.dout_oe_n = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q           <= '0;
         q.cs_sy     <= '1;
         q.dout_oe_n <= 1'b1;
         q.eoc       <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign link.dout      = q.dout;
   assign link.dout_oe_n = q.dout_oe_n;
   assign link.eoc       = q.eoc;
   assign chan_q         = q.chan;
   assign result_q       = q.result;
   assign busy_q         = q.conv;
   assign sync_lost_q    = q.lost;

endmodule // asac_dev

//--- src/asac_pkg.sv
// Constants shared by the converter select/abort control and its host end.
// Both ends are assumed to run on one 200 MHz system clock.
package asac_pkg;

   // System clock.
   localparam int SYS_CLK_MHZ = 200;

   // Counter widths.
   localparam int TMR_W      = 12;
   localparam int CNT_W      = 5;
   localparam int INT_DIV_W  = 5;

   // Field widths.
   localparam int ADDR_BITS  = 4;
   localparam int RES_BITS   = 10;
   localparam int LEVEL_BITS = 12;

   // Transfer shape.
   localparam int XFER_CLKS   = 16;
   localparam int SAMPLE_EDGE = 10;

   // Least select-low time before the first address edge, rounded up to cycles.
   localparam int CS_SETUP_NS  = 1425;
   localparam int CS_SETUP_CYC = (CS_SETUP_NS * SYS_CLK_MHZ + 999) / 1000;

   // Fastest shift clock; the host's half period is rounded up to cycles.
   localparam int SCLK_MAX_KHZ  = 2100;
   localparam int SCLK_HALF_CYC = (SYS_CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);

   // Noise filter on the device after select falls, before two internal clock falls.
   localparam int FILTER_NS  = 1000;
   localparam int FILTER_CYC = (FILTER_NS * SYS_CLK_MHZ + 999) / 1000;

   // Conversion time of the model, in system clock cycles.
   localparam int CONV_CYC = 1000;

   localparam logic [TMR_W-1:0] SETUP_TMR  = TMR_W'(CS_SETUP_CYC);
   localparam logic [TMR_W-1:0] HALF_TMR   = TMR_W'(SCLK_HALF_CYC);
   localparam logic [TMR_W-1:0] FILTER_TMR = TMR_W'(FILTER_CYC);
   localparam logic [TMR_W-1:0] CONV_TMR   = TMR_W'(CONV_CYC);
   localparam logic [TMR_W-1:0] GAP_TMR    = TMR_W'(SCLK_HALF_CYC);

   localparam logic [CNT_W-1:0] ADDR_LAST_RISE = CNT_W'(ADDR_BITS - 1);
   localparam logic [CNT_W-1:0] LAST_SAMPLE    = CNT_W'(SAMPLE_EDGE - 1);
   localparam logic [CNT_W-1:0] SAMPLE_CNT     = CNT_W'(SAMPLE_EDGE);
   localparam logic [CNT_W-1:0] RX_BITS        = CNT_W'(RES_BITS);
   localparam logic [CNT_W-1:0] XFER_CNT       = CNT_W'(XFER_CLKS);

   // Self-test addresses and their fixed results.
   localparam logic [ADDR_BITS-1:0] ADDR_TEST_MID = 4'hB;
   localparam logic [ADDR_BITS-1:0] ADDR_TEST_LO  = 4'hC;
   localparam logic [ADDR_BITS-1:0] ADDR_TEST_HI  = 4'hD;
   localparam logic [RES_BITS-1:0]  RES_MID       = 10'h200;
   localparam logic [RES_BITS-1:0]  RES_ZERO      = 10'h000;
   localparam logic [RES_BITS-1:0]  RES_FULL      = 10'h3FF;

endpackage

//--- src/asac_link_if.sv
// Four-wire serial link between the converter control and its host, plus end-of-conversion.
// The testbench instantiates it and joins both ends; a released data line is modelled without a floating level.
`timescale 1ns/1ps
interface asac_link_if;
   logic cs_n;
   logic io_clk;
   logic addr;
   logic dout;
   logic dout_oe_n;
   logic eoc;
   wire  dout_line;

   // A released data line shows the inverse of the last bit, so a host that samples it too early sees a wrong value.
   assign dout_line = dout_oe_n ? ~dout : dout;

   modport dev  (input cs_n, input io_clk, input addr, output dout, output dout_oe_n, output eoc);
   modport host (output cs_n, output io_clk, output addr, input dout_line, input eoc);
endinterface

//--- src/asac_host.sv
// Host end: drives select, shift clock and address, and collects the serial result.
// Assumes the device end sits on the far side of the link interface.
`timescale 1ns/1ps
module asac_host (
   input  wire logic                               sys_clk,
   input  wire logic                               rst_n,
   asac_link_if.host                               link,
   input  wire logic                               start,
   input  wire logic [asac_pkg::ADDR_BITS-1:0]     chan,
   input  wire logic                               abort,
   output logic                                    busy_q,
   output logic      [asac_pkg::RES_BITS-1:0]      result_q,
   output logic                                    result_valid_q
);

   typedef enum logic [2:0] {
      ASAC_H_IDLE,
      ASAC_H_SETUP,
      ASAC_H_HIGH,
      ASAC_H_LOW,
      ASAC_H_EOC,
      ASAC_H_GAP
   } asac_host_mode_t;

   typedef struct packed {
      asac_host_mode_t                     mode;
      logic [asac_pkg::TMR_W-1:0]          tmr;
      logic [asac_pkg::CNT_W-1:0]          nclk;
      logic [asac_pkg::ADDR_BITS-1:0]      chan;
      logic [asac_pkg::ADDR_BITS-1:0]      addr_sh;
      logic [asac_pkg::RES_BITS-1:0]       rx;
      logic [1:0]                          dout_sy;
      logic [1:0]                          eoc_sy;
      logic                                cs_n;
      logic                                io_clk;
      logic                                addr;
      logic                                busy;
      logic [asac_pkg::RES_BITS-1:0]       result;
      logic                                valid;
   } asac_host_st_t;

   asac_host_st_t q;
   asac_host_st_t d;

   always_comb begin
      d         = q;
      d.dout_sy = {q.dout_sy[0], link.dout_line};
      d.eoc_sy  = {q.eoc_sy[0], link.eoc};
      d.valid   = 1'b0;
      if (q.tmr != '0) begin
         d.tmr = q.tmr - 1'b1;
      end
      unique case (q.mode)
         ASAC_H_IDLE: begin
            if (start) begin
               d.chan    = chan;
               d.addr_sh = chan;
               d.addr    = chan[asac_pkg::ADDR_BITS-1];
               d.cs_n    = 1'b0;
               d.tmr     = asac_pkg::SETUP_TMR;
               d.nclk    = '0;
               d.busy    = 1'b1;
               d.mode    = ASAC_H_SETUP;
            end
         end
         ASAC_H_SETUP, ASAC_H_LOW: begin
            if (q.tmr == '0) begin
               if (q.nclk == asac_pkg::XFER_CNT) begin
                  d.cs_n = 1'b1;
                  d.mode = ASAC_H_EOC;
               end else begin
                  // Rising edge after the setup wait or a low half period.
                  d.io_clk = 1'b1;
                  d.nclk   = q.nclk + 1'b1;
                  if (q.nclk < asac_pkg::RX_BITS) begin
                     d.rx = {q.rx[asac_pkg::RES_BITS-2:0], q.dout_sy[1]};
                  end
                  d.tmr  = asac_pkg::HALF_TMR;
                  d.mode = ASAC_H_HIGH;
               end
            end
         end
         ASAC_H_HIGH: begin
            if (q.tmr == '0) begin
               // A half period low keeps every rise, the eleventh too, well inside the deadline.
               d.io_clk  = 1'b0;
               d.addr_sh = {q.addr_sh[asac_pkg::ADDR_BITS-2:0], 1'b0};
               d.addr    = q.addr_sh[asac_pkg::ADDR_BITS-2];
               d.tmr     = asac_pkg::HALF_TMR;
               d.mode    = ASAC_H_LOW;
            end
         end
         ASAC_H_EOC: begin
            // Select stays high until the conversion is over.
            if (q.eoc_sy[1]) begin
               d.result = q.rx;
               d.valid  = 1'b1;
               d.busy   = 1'b0;
               d.mode   = ASAC_H_IDLE;
            end
         end
         ASAC_H_GAP: begin
            if (q.tmr == '0) begin
               d.cs_n    = 1'b0;
               d.addr_sh = q.chan;
               d.addr    = q.chan[asac_pkg::ADDR_BITS-1];
               d.tmr     = asac_pkg::SETUP_TMR;
               d.nclk    = '0;
               d.rx      = '0;
               d.mode    = ASAC_H_SETUP;
            end
         end
         default: begin
            d.mode = ASAC_H_IDLE;
         end
      endcase
      // Abort raises select for a gap and then restarts with a new falling edge.
      if (abort && q.busy && q.mode != ASAC_H_GAP) begin
         d.cs_n   = 1'b1;
         d.io_clk = 1'b0;
         d.tmr    = asac_pkg::GAP_TMR;
         d.mode   = ASAC_H_GAP;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         q      <= '0;
         q.cs_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign link.cs_n      = q.cs_n;
   assign link.io_clk    = q.io_clk;
   assign link.addr      = q.addr;
   assign busy_q         = q.busy;
   assign result_q       = q.result;
   assign result_valid_q = q.valid;

endmodule // asac_host

//--- sim/asac_properties.sv
// Link checker for the select/abort control: select, shift clock, address and data float timing.
// Assumes both ends share one link interface and the 200 MHz sys_clk.
`timescale 1ns/1ps
module asac_properties (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic io_clk,
   input wire logic addr,
   input wire logic dout_oe_n,
   input wire logic eoc
);
   logic [11:0] sel_cnt_q;
   logic [7:0]  half_cnt_q;

   // Cycles since select went low, and cycles since the shift clock last moved.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_cnt_q  <= 12'h000;
         half_cnt_q <= 8'h00;
      end else begin
         sel_cnt_q  <= cs_n ? 12'h000 : sel_cnt_q + {11'h000, sel_cnt_q != 12'hFFF};
         half_cnt_q <= $changed(io_clk) ? 8'h01 : half_cnt_q + {7'h00, half_cnt_q != 8'hFF};
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_select_drives_data: assert property (
      $fell(cs_n) |-> ##[1:6] !dout_oe_n) else $error("data line not driven after select fall");
   a_convert_in_select: assert property (
      $fell(eoc) |-> !cs_n && !dout_oe_n) else $error("conversion began outside a transfer");
   a_deselect_floats: assert property (
      $rose(cs_n) |-> ##[1:6] dout_oe_n) else $error("data line still driven after select rise");
   a_idle_floats: assert property (
      cs_n [*8] |-> dout_oe_n) else $error("data line driven while deselected");
   a_settle_before_start: assert property (
      $fell(eoc) |-> sel_cnt_q > asac_pkg::FILTER_TMR) else $error("conversion began inside settle time");
   a_abort_ends_cycle: assert property (
      $fell(cs_n) && !eoc |-> ##[1:8] eoc) else $error("select fall did not abort the conversion");
   a_setup_before_addr: assert property (
      $rose(io_clk) |-> sel_cnt_q >= asac_pkg::SETUP_TMR) else $error("shift clock rose too soon after select");
   a_clock_half_period: assert property (
      $changed(io_clk) && !cs_n |-> half_cnt_q >= asac_pkg::HALF_TMR) else $error("shift clock phase too short");
   a_addr_held: assert property (
      $rose(io_clk) && !cs_n |-> $stable(addr) && $past(addr, 8) == addr) else $error("address moved near rise");

   c_abort: cover property ($fell(cs_n) && !eoc);
   c_conv_done: cover property ($rose(eoc));
   c_first_rise: cover property ($rose(io_clk) && sel_cnt_q == asac_pkg::SETUP_TMR + 12'h001);
endmodule // asac_properties

//--- sim/adc_select_abort_control_tb.sv
// Testbench: host and converter ends joined on one link, plus a converter driven straight by the bench.
// Assumes the design files under src/ are compiled first.
`timescale 1ns/1ps
module adc_select_abort_control_tb;
   logic        sys_clk;
   logic        rst_n;
   logic        start;
   logic        abort;
   logic [3:0]  chan;
   logic [11:0] ain;
   logic [11:0] ref_lo;
   logic [11:0] ref_hi;
   logic        h_busy;
   logic [9:0]  h_res;
   logic        h_valid;
   logic [3:0]  d_chan;
   logic [9:0]  d_res;
   logic        d_busy;
   logic        d_lost;
   logic [3:0]  e_chan;
   logic [9:0]  e_res;
   logic        e_busy;
   logic        e_lost;
   logic [9:0]  prev;
   logic [9:0]  rx2;
   int          n_errors;
   int          samples_checked;
   logic [49:0] tv [10];

   asac_link_if link1();
   asac_link_if link2();

   asac_host asac_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link1), .start(start), .chan(chan),
      .abort(abort), .busy_q(h_busy), .result_q(h_res), .result_valid_q(h_valid));
   asac_dev asac_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link1), .ain_level(ain), .ref_lo(ref_lo),
      .ref_hi(ref_hi), .chan_q(d_chan), .result_q(d_res), .busy_q(d_busy), .sync_lost_q(d_lost));
   asac_dev asac_dev_solo_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link2), .ain_level(ain), .ref_lo(ref_lo),
      .ref_hi(ref_hi), .chan_q(e_chan), .result_q(e_res), .busy_q(e_busy), .sync_lost_q(e_lost));
   asac_properties asac_properties_i (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(link1.cs_n),
      .io_clk(link1.io_clk), .addr(link1.addr), .dout_oe_n(link1.dout_oe_n), .eoc(link1.eoc));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One host conversion; ab 1 aborts once the conversion runs, ab 2 after two address clocks.
   task automatic host_conv(input logic [3:0] c, input logic [35:0] lv, input logic [9:0] exp, input int ab);
      int k;
      @(negedge sys_clk);
      {ain, ref_lo, ref_hi} = lv;
      chan  = c;
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      if (ab == 1) @(negedge link1.eoc);
      if (ab == 2) repeat (2) @(posedge link1.io_clk);
      if (ab != 0) begin
         @(negedge sys_clk);
         check(16'(h_busy), 16'h0001);
         if (ab == 1) check(16'(d_busy), 16'h0001);
         abort = 1'b1;
         @(negedge sys_clk);
         abort = 1'b0;
         repeat (70) @(negedge sys_clk);
         check(16'(link1.eoc), 16'h0001);
         check(16'(d_res), 16'(prev));
         check(16'(d_busy), 16'h0000);
      end
      for (k = 0; k < 6000 && h_valid !== 1'b1; k++) @(posedge sys_clk) #1;
      check(16'(h_valid), 16'h0001);
      check(16'(h_busy), 16'h0000);
      check(16'(d_chan), 16'(c));
      check(16'(d_res), 16'(exp));
      check(16'(h_res), 16'(prev));
      prev = exp;
   endtask

   task automatic sel2(input logic v, input int ns);
      link2.cs_n = v;
      #(ns);
   endtask

   // Address goes out MSB first and is changed only while the shift clock is low.
   task automatic xfer2(input logic [3:0] a, input int n);
      int i;
      link2.addr = a[3];
      for (i = 0; i < n; i++) begin
         link2.io_clk = 1'b1;
         #40;
         if (i < 10) rx2 = {rx2[8:0], link2.dout_line};
         link2.io_clk = 1'b0;
         link2.addr   = (i < 3) ? a[2-i] : 1'b0;
         #40;
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      #400000;
      n_errors++;
      $display("MISMATCH at %0t: run did not finish", $time);
      end_of_test();
   end

   initial begin
      {rst_n, start, abort, chan, prev, rx2} = '0;
      {ain, ref_lo, ref_hi} = {12'h000, 12'h000, 12'hFFF};
      {link2.cs_n, link2.io_clk, link2.addr} = 3'b100;
      tv = '{{4'h0, 12'h150, 12'h100, 12'h500, 10'h050}, {4'h1, 12'h100, 12'h100, 12'h500, 10'h000},
             {4'h2, 12'h0F0, 12'h100, 12'h500, 10'h000}, {4'h3, 12'h500, 12'h100, 12'h500, 10'h3FF},
             {4'h4, 12'h600, 12'h100, 12'h500, 10'h3FF}, {4'h5, 12'h900, 12'h100, 12'hF00, 10'h3FF},
             {4'hA, 12'h37F, 12'h000, 12'hFFF, 10'h37F}, {4'hB, 12'h37F, 12'h000, 12'hFFF, 10'h200},
             {4'hC, 12'h37F, 12'h000, 12'hFFF, 10'h000}, {4'hD, 12'h000, 12'h000, 12'hFFF, 10'h3FF}};
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      xfer2(4'hF, 4);
      check(16'(e_chan), 16'h0000);
      check(16'(link2.dout_oe_n), 16'h0001);
      sel2(1'b0, 100);
      xfer2(4'hF, 4);
      check(16'(e_chan), 16'h0000);
      check(16'(link2.dout_oe_n), 16'h0000);
      sel2(1'b1, 200);
      sel2(1'b0, 1500);
      xfer2(4'h9, 2);
      sel2(1'b1, 200);
      sel2(1'b0, 1500);
      {ain, ref_lo, ref_hi} = {12'h1A5, 12'h000, 12'hFFF};
      xfer2(4'h6, 16);
      check(16'(e_chan), 16'h0006);
      sel2(1'b1, 100);
      check(16'(link2.dout_oe_n), 16'h0001);
      #5000;
      sel2(1'b0, 1500);
      xfer2(4'h6, 16);
      check(16'(rx2), 16'h01A5);
      check(16'(e_res), 16'h01A5);
      sel2(1'b1, 6000);
      sel2(1'b0, 1500);
      ain = 12'h0F0;
      xfer2(4'h6, 10);
      #6000;
      check(16'(e_lost), 16'h0001);
      check(16'(e_res), 16'h01A5);
      sel2(1'b1, 100);
      sel2(1'b0, 1500);
      check(16'(e_lost), 16'h0000);
      xfer2(4'hD, 10);
      check(16'(link2.eoc), 16'h0000);
      sel2(1'b1, 100);
      sel2(1'b0, 100);
      check(16'(link2.eoc), 16'h0001);
      #6000;
      check(16'(e_res), 16'h01A5);
      check(16'(e_busy), 16'h0000);
      sel2(1'b1, 100);
      for (int i = 0; i < 10; i++) host_conv(tv[i][49:46], tv[i][45:10], tv[i][9:0], 0);
      host_conv(4'h0, {12'h223, 12'h100, 12'h500}, 10'h123, 1);
      host_conv(4'h7, {12'h177, 12'h100, 12'h500}, 10'h077, 2);
      end_of_test();
   end
endmodule // adc_select_abort_control_tb
